/* File: logic/sirq_level_status.sv */
// Level-mode interrupt status flags for a sixteen-slot serial interrupt stream
//
// How it works
// - Level-mode asserted slot sets its flag
// - Writing one clears flag, re-arms line
// - Edge-mode lines never set, read zero
// - Sixteen flags, bit n is line n
// - Link, global or power-on reset clears
// - Memory 4Ch and config E4h share flags
// - Mode bit zero edge, one level
// - Mode bits read/write at offset 4Ah
`include "sirq_params.svh"

module sirq_level_status (
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire logic                   express_link_reset_pin_n,
    input  wire logic                   global_reset_pin_n,
    input  wire logic [`SIRQ_LINES-1:0] serial_interrupt_line,
    input  wire sirq_pkg::reg_req_t     mem_req,
    input  wire sirq_pkg::reg_req_t     cfg_req,
    output sirq_pkg::reg_rsp_t          mem_rsp,
    output sirq_pkg::reg_rsp_t          cfg_rsp,
    output logic [`SIRQ_LINES-1:0]      level_flags
);

    logic [`SIRQ_LINES-1:0] flags_q;       // Shared level flag storage
    logic [`SIRQ_LINES-1:0] flags_d;       // Next flag value
    logic [`SIRQ_LINES-1:0] mode_q;        // Per-line trigger select
    logic [`SIRQ_LINES-1:0] set_vec;       // Level assertions this cycle
    logic [`SIRQ_LINES-1:0] clr_vec;       // Clears from either path
    logic [`SIRQ_LINES-1:0] mem_clr;       // Clear mask, memory window
    logic [`SIRQ_LINES-1:0] cfg_clr;       // Clear mask, config alias
    logic                   mem_mode_we;   // Mode write, memory window
    logic                   cfg_mode_we;   // Mode write, config alias
    logic                   mem_sel_st;    // Status selected, memory
    logic                   mem_sel_md;    // Mode selected, memory
    logic                   cfg_sel_st;    // Status selected, config
    logic                   cfg_sel_md;    // Mode selected, config
    logic                   ext_rst;       // Either reset pin active
    sirq_pkg::reg_rsp_t     mem_rsp_q;     // Registered memory answer
    sirq_pkg::reg_rsp_t     cfg_rsp_q;     // Registered config answer

    // Reset pins are synchronous to clk and reset flags and mode like power-on reset
    // Either pin alone is enough; resetn stays the only asynchronous path
    assign ext_rst = !express_link_reset_pin_n || !global_reset_pin_n;

    // Each path has its own decoder so that both may run in one cycle
    // Memory window decode
    sirq_port_decode #(
        .MODE_OFS   (`SIRQ_MEM_MODE),
        .STATUS_OFS (`SIRQ_MEM_STATUS)
    ) u_mem_dec (
        .req          (mem_req),
        .status_clear (mem_clr),
        .mode_we      (mem_mode_we),
        .sel_status   (mem_sel_st),
        .sel_mode     (mem_sel_md)
    );

    // Configuration space alias decode
    sirq_port_decode #(
        .MODE_OFS   (`SIRQ_CFG_MODE),
        .STATUS_OFS (`SIRQ_CFG_STATUS)
    ) u_cfg_dec (
        .req          (cfg_req),
        .status_clear (cfg_clr),
        .mode_we      (cfg_mode_we),
        .sel_status   (cfg_sel_st),
        .sel_mode     (cfg_sel_md)
    );

    // Both paths clear the same storage; a clear from either is honoured
    assign clr_vec = mem_clr | cfg_clr;

    // Trigger select register; memory window wins a same-cycle collision
    // No byte lanes: a mode write always replaces all sixteen bits
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= `SIRQ_MODE_RESET;
        end else if (ext_rst) begin
            mode_q <= `SIRQ_MODE_RESET;
        end else if (mem_mode_we) begin
            mode_q <= mem_req.wdata;
        end else if (cfg_mode_we) begin
            mode_q <= cfg_req.wdata;
        end
    end

    // Per-line flag logic
    // Edge lines are masked here, not at the stream input, so a line
    // switched to edge mode loses its flag at the next edge
    genvar gi;
    generate
        for (gi = 0; gi < `SIRQ_LINES; gi++) begin : g_line
            // Only level-mode lines may report
            assign set_vec[gi] = mode_q[gi] && serial_interrupt_line[gi];
            // Set wins over clear; edge mode forces zero
            assign flags_d[gi] = mode_q[gi]
                && (set_vec[gi] || (flags_q[gi] && !clr_vec[gi]));
        end
    endgenerate

    // Shared flag storage, bit n is line n
    // Pin resets act at the edge they are seen; responses keep answering
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags_q <= `SIRQ_FLAGS_RESET;
        end else if (ext_rst) begin
            flags_q <= `SIRQ_FLAGS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Memory window answer; reads show the value before this cycle's update
    // Ack follows valid for writes and unmapped offsets alike
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mem_rsp_q <= '0;
        end else begin
            mem_rsp_q.ack <= mem_req.valid;
            if (mem_sel_st && !mem_req.write) begin
                mem_rsp_q.rdata <= flags_q;
            end else if (mem_sel_md && !mem_req.write) begin
                mem_rsp_q.rdata <= mode_q;
            end else begin
                mem_rsp_q.rdata <= `SIRQ_READ_ZERO;  // Unmapped or write
            end
        end
    end

    // Configuration alias answer, same storage as the memory window
    // A read never clears anything; only a written one does
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_rsp_q <= '0;
        end else begin
            cfg_rsp_q.ack <= cfg_req.valid;
            if (cfg_sel_st && !cfg_req.write) begin
                cfg_rsp_q.rdata <= flags_q;
            end else if (cfg_sel_md && !cfg_req.write) begin
                cfg_rsp_q.rdata <= mode_q;
            end else begin
                cfg_rsp_q.rdata <= `SIRQ_READ_ZERO;  // Unmapped or write
            end
        end
    end

    // Outputs straight from flops
    // Flag copy lets a host watch the flags without a bus access
    assign mem_rsp     = mem_rsp_q;
    assign cfg_rsp     = cfg_rsp_q;
    assign level_flags = flags_q;

    // Checks, all on clk; power-on reset switches them off, while pin
    // resets stay visible so that their own effect can be checked
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Capture: a level line seen now is a flag after the next edge
    a_level_capture: assert property (
        !ext_rst |=> ((flags_q & $past(set_vec)) == $past(set_vec)))
        else $error("Level assertion not captured");
    // Clear: a written one with no fresh assertion empties the flag
    a_clear_rearm: assert property (
        !ext_rst |=> ((flags_q & $past(clr_vec & ~set_vec)) == '0))
        else $error("Written one did not clear flag");
    // Edge lines stay silent whatever the stream shows
    a_edge_silent: assert property (
        1'b1 |=> ((flags_q & ~$past(mode_q)) == '0))
        else $error("Edge mode line reported");
    // No flag rises without its own line asserted
    a_no_spurious: assert property (
        !ext_rst |=> ((flags_q & ~$past(flags_q) & ~$past(set_vec)) == '0))
        else $error("Flag set without assertion");
    // Either reset pin empties the flags at the edge it is seen
    a_pin_reset: assert property (
        ext_rst |=> (flags_q == `SIRQ_FLAGS_RESET))
        else $error("Reset pin did not clear flags");
    // Both paths read the one shared storage
    a_mem_alias: assert property (
        mem_sel_st && !mem_req.write |=> (mem_rsp.rdata == $past(flags_q)) && mem_rsp.ack)
        else $error("Memory window status read wrong");
    a_cfg_alias: assert property (
        cfg_sel_st && !cfg_req.write |=> (cfg_rsp.rdata == $past(flags_q)) && cfg_rsp.ack)
        else $error("Config alias status read wrong");
    // Every request is answered on the next cycle, writes too
    a_mem_answer: assert property (
        mem_req.valid |=> mem_rsp.ack)
        else $error("Memory window request not answered");
    a_cfg_answer: assert property (
        cfg_req.valid |=> cfg_rsp.ack)
        else $error("Config alias request not answered");
    // Either reset pin puts every line back in edge mode
    a_mode_reset: assert property (
        ext_rst |=> (mode_q == `SIRQ_MODE_RESET))
        else $error("Reset pin did not clear mode");
    // Mode writes land; the memory window wins a same-cycle collision
    a_mode_write: assert property (
        !ext_rst && mem_mode_we |=> (mode_q == $past(mem_req.wdata)))
        else $error("Mode write not stored");
    a_cfg_mode_write: assert property (
        !ext_rst && cfg_mode_we && !mem_mode_we |=> (mode_q == $past(cfg_req.wdata)))
        else $error("Config mode write not stored");
    // Mode readback shows the stored selection
    a_mode_read: assert property (
        mem_sel_md && !mem_req.write |=> (mem_rsp.rdata == $past(mode_q)))
        else $error("Mode read wrong");
    // A set flag on a level-mode line is kept, outside pin resets, until a one is written to it
    a_flag_hold: assert property (
        !ext_rst |=> ((flags_q & $past(flags_q & ~clr_vec & mode_q))
            == $past(flags_q & ~clr_vec & mode_q)))
        else $error("Set flag lost without clear");

    // Main scenarios the stimulus should reach
    c_capture: cover property (set_vec != '0 ##1 flags_q != '0);
    c_clear_collide: cover property ((set_vec & clr_vec) != '0);
    c_cfg_clear: cover property (flags_q != '0 && cfg_clr != '0 ##1 flags_q == '0);
    c_cfg_mode: cover property (cfg_mode_we ##1 mode_q != '0);
    c_edge_blocked: cover property ((serial_interrupt_line & ~mode_q) != '0);

endmodule : sirq_level_status

/* File: logic/sirq_params.svh */
// Constants for the serial interrupt level status block
`ifndef SIRQ_PARAMS_SVH
`define SIRQ_PARAMS_SVH

`define SIRQ_LINES       16        // Interrupt slots carried by the serial stream
`define SIRQ_ADDR_W      8         // Register port address width
`define SIRQ_MEM_MODE    8'h4A     // Trigger select, memory window
`define SIRQ_MEM_STATUS  8'h4C     // Level flags, memory window
`define SIRQ_CFG_MODE    8'hE2     // Trigger select, configuration space alias
`define SIRQ_CFG_STATUS  8'hE4     // Level flags, configuration space alias
`define SIRQ_FLAGS_RESET 16'h0000  // Level flags after any reset
`define SIRQ_MODE_RESET  16'h0000  // All lines edge mode after reset
`define SIRQ_READ_ZERO   16'h0000  // Answer for unmapped offsets

`endif

/* File: logic/sirq_pkg.sv */
// Types shared by the serial interrupt level status block
`include "sirq_params.svh"

package sirq_pkg;

    // One register access request
    typedef struct packed {
        logic                      valid;  // Access this cycle
        logic                      write;  // 1 write, 0 read
        logic [`SIRQ_ADDR_W-1:0]   addr;   // Register offset
        logic [`SIRQ_LINES-1:0]    wdata;  // Write data
    } reg_req_t;

    // One register access answer
    typedef struct packed {
        logic                      ack;    // One cycle after the request
        logic [`SIRQ_LINES-1:0]    rdata;  // Read data, zero for writes
    } reg_rsp_t;

endpackage : sirq_pkg

/* File: logic/sirq_port_decode.sv */
// Offset decoder for one register access path
`include "sirq_params.svh"

module sirq_port_decode #(
    parameter logic [`SIRQ_ADDR_W-1:0] MODE_OFS   = `SIRQ_MEM_MODE,
    parameter logic [`SIRQ_ADDR_W-1:0] STATUS_OFS = `SIRQ_MEM_STATUS
) (
    input  wire sirq_pkg::reg_req_t     req,
    output logic [`SIRQ_LINES-1:0]      status_clear,
    output logic                        mode_we,
    output logic                        sel_status,
    output logic                        sel_mode
);

    // Pure decode; the caller registers the answer
    always_comb begin
        sel_status   = req.valid && (req.addr == STATUS_OFS);
        sel_mode     = req.valid && (req.addr == MODE_OFS);
        mode_we      = sel_mode && req.write;
        // Write one to clear; zeros leave the flag alone
        status_clear = (sel_status && req.write) ? req.wdata : `SIRQ_FLAGS_RESET;
    end

endmodule : sirq_port_decode

/* File: testbench/sirq_level_status_test.sv */
// Self-checking bench for the serial interrupt level status block
`include "sirq_params.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module sirq_level_status_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk;                       // 25 MHz clock
    logic               resetn;                    // Power-on reset, active low
    logic               express_link_reset_pin_n;  // Link reset pin
    logic               global_reset_pin_n;        // Global reset pin
    logic [15:0]        raise_mask;                // Requested slot pattern
    logic [15:0]        slots;                     // Model output into block
    logic [15:0]        level_flags;               // Flag copy from block
    logic [15:0]        m;                         // Random trigger selection
    logic [15:0]        w;                         // Random clear mask
    logic [15:0]        e;                         // Oldest expected read data
    sirq_pkg::reg_req_t mem_req;                   // Memory window request
    sirq_pkg::reg_req_t cfg_req;                   // Config alias request
    sirq_pkg::reg_rsp_t mem_rsp;                   // Memory window answer
    sirq_pkg::reg_rsp_t cfg_rsp;                   // Config alias answer
    logic [15:0]        exp_q[$];                  // Expected answers in order
    int                 errors;                    // Mismatch count
    int                 tests_run;                 // Comparison count

    sirq_stream_model sirq_stream_model_inst (.clk(clk), .raise_mask(raise_mask),
                                              .slots(slots));
    sirq_level_status sirq_level_status_inst (
        .clk(clk), .resetn(resetn), .express_link_reset_pin_n(express_link_reset_pin_n),
        .global_reset_pin_n(global_reset_pin_n), .serial_interrupt_line(slots),
        .mem_req(mem_req), .cfg_req(cfg_req), .mem_rsp(mem_rsp), .cfg_rsp(cfg_rsp),
        .level_flags(level_flags));

    // Free-running 40 ns clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // One access on either path; the answer is noted for the monitor
    task automatic acc(input logic cfg, input logic wr, input logic [7:0] a,
                       input logic [15:0] d, input logic [15:0] ex);
        sirq_pkg::reg_req_t r;
        r = '{valid: 1'b1, write: wr, addr: a, wdata: d};
        exp_q.push_back(ex);
        @(posedge clk);
        #1;
        if (cfg) begin
            cfg_req = r;
        end else begin
            mem_req = r;
        end
        @(posedge clk);
        #1;
        mem_req.valid = 1'b0;
        cfg_req.valid = 1'b0;
    endtask : acc

    // Verdict; also reached from the watchdog
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    // Monitor: ack stands one cycle, so look just after each edge
    always @(posedge clk) begin
        #2;
        if (mem_rsp.ack === 1'b1 || cfg_rsp.ack === 1'b1) begin
            e = exp_q.pop_front();
            if (mem_rsp.ack === 1'b1) begin
                `CHK("mem rdata", e, mem_rsp.rdata)
            end else begin
                `CHK("cfg rdata", e, cfg_rsp.rdata)
            end
        end
    end

    // Watchdog, the whole run needs about 80 cycles
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        stop_test();
    end

    // Main sequence
    initial begin
        void'($urandom(13315));
        resetn = 1'b0;
        express_link_reset_pin_n = 1'b1;
        global_reset_pin_n = 1'b1;
        raise_mask = 16'h0000;
        mem_req = '0;
        cfg_req = '0;
        errors = 0;
        tests_run = 0;
        repeat (12) @(posedge clk);
        #1 resetn = 1'b1;
        acc(1'b0, 1'b0, `SIRQ_MEM_STATUS, 16'h0000, `SIRQ_FLAGS_RESET);
        acc(1'b1, 1'b0, `SIRQ_CFG_STATUS, 16'h0000, `SIRQ_FLAGS_RESET);
        acc(1'b0, 1'b0, `SIRQ_MEM_MODE, 16'h0000, `SIRQ_MODE_RESET);
        // Pass 0 ends in a link reset, pass 1 in a global reset
        for (int k = 0; k < 2; k++) begin
            // Lines 15 and 0 always level, 14 and 7 always edge
            m = (16'($urandom) | 16'h8001) & 16'hBF7F;
            w = 16'($urandom);
            // Pass 0 writes mode through memory, pass 1 through config
            acc(k[0], 1'b1, k[0] ? `SIRQ_CFG_MODE : `SIRQ_MEM_MODE, m, 16'h0000);
            acc(!k[0], 1'b0, k[0] ? `SIRQ_MEM_MODE : `SIRQ_CFG_MODE, 16'h0000, m);
            raise_mask = 16'hFFFF;
            repeat (3) @(posedge clk);
            #1 raise_mask = 16'h0000;
            repeat (3) @(posedge clk);
            #1;
            `CHK("level flags", m, level_flags)
            acc(1'b0, 1'b0, `SIRQ_MEM_STATUS, 16'h0000, m);
            acc(1'b1, 1'b1, `SIRQ_CFG_STATUS, w, 16'h0000);
            acc(1'b0, 1'b0, `SIRQ_MEM_STATUS, 16'h0000, m & ~w);
            // Slots held asserted across a full clear: set must win
            raise_mask = 16'hFFFF;
            acc(1'b0, 1'b1, `SIRQ_MEM_STATUS, 16'hFFFF, 16'h0000);
            acc(1'b1, 1'b0, `SIRQ_CFG_STATUS, 16'h0000, m);
            raise_mask = 16'h0000;
            acc(1'b1, 1'b0, 8'h50, 16'h0000, `SIRQ_READ_ZERO);
            acc(1'b0, 1'b0, `SIRQ_MEM_STATUS, 16'h0000, m);
            if (k == 0) begin
                express_link_reset_pin_n = 1'b0;
            end else begin
                global_reset_pin_n = 1'b0;
            end
            @(posedge clk);
            #1;
            express_link_reset_pin_n = 1'b1;
            global_reset_pin_n = 1'b1;
            acc(1'b0, 1'b0, `SIRQ_MEM_STATUS, 16'h0000, `SIRQ_FLAGS_RESET);
            acc(1'b1, 1'b0, `SIRQ_CFG_MODE, 16'h0000, `SIRQ_MODE_RESET);
        end
        repeat (2) @(posedge clk);
        // Every noted answer must have arrived
        `CHK("pending answers", 32'h0, exp_q.size())
        stop_test();
    end
endmodule : sirq_level_status_test

/* File: testbench/sirq_stream_model.sv */
// Far-side model: serial interrupt stream decoder feeding slot states
module sirq_stream_model (
    input  wire logic        clk,         // Stream runs on the block clock
    input  wire logic [15:0] raise_mask,  // Slots the bench asks to assert
    output logic      [15:0] slots        // Decoded slot states, 1 = asserted
);
    timeunit 1ns;
    timeprecision 1ps;

    // A decoder presents slots one frame step late, never combinationally
    always_ff @(posedge clk) begin
        slots <= raise_mask;
    end
endmodule : sirq_stream_model
